// ==== verilog/piu_pkg.sv ====
// shared constants for the priority interrupt and exception unit
package piu_pkg;
    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] PIU_OFF_PRIORITY = 8'h00;
    localparam logic [7:0] PIU_OFF_SOFT_REQ = 8'h04;
    localparam logic [7:0] PIU_OFF_SOFT_SUM = 8'h08;
    localparam logic [7:0] PIU_OFF_STATUS = 8'h0C;
    // ------------------------------------------------------------
    // priority levels
    // ------------------------------------------------------------
    localparam logic [4:0] PIU_LVL_TOP = 5'h1F;
    localparam logic [4:0] PIU_LVL_HW_BASE = 5'h10;
    localparam logic [4:0] PIU_LVL_PROCESS = 5'h00;
    localparam int PIU_HW_LEVELS = 16;
    localparam int PIU_SOFT_LEVELS = 16;
    // ------------------------------------------------------------
    // status word field layout
    // ------------------------------------------------------------
    localparam int PIU_SW_TEN_LO = 5;
    localparam int PIU_SW_TEN_HI = 7;
    localparam int PIU_SW_PRI_LO = 16;
    localparam int PIU_SW_PRI_HI = 20;
    localparam int PIU_SW_PMODE_LO = 22;
    localparam int PIU_SW_PMODE_HI = 23;
    localparam int PIU_SW_CMODE_LO = 24;
    localparam int PIU_SW_CMODE_HI = 25;
    localparam int PIU_SW_ISTACK = 26;
    localparam int PIU_SW_FPD = 27;
    localparam int PIU_SW_TP = 30;
    localparam logic [31:0] PIU_SW_RESET = 32'h001F_0000;
    localparam logic [31:0] PIU_SOFT_SUM_RESET = 32'h0000_0000;
    localparam logic [1:0] PIU_MODE_KERNEL = 2'h0;
    // ------------------------------------------------------------
    // exception classes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PIU_EXC_TRAP = 2'b00,
        PIU_EXC_FAULT = 2'b01,
        PIU_EXC_ABORT = 2'b10
    } piu_exc_class_t;
endpackage

// ==== verilog/piu_unit.sv ====
// priority arbitration, exception initiation and register file of one processor
//
// How it works
// - levels 01-0F are software, 10-1F hardware, process runs at zero.
// - the highest outstanding level always wins arbitration.
// - a level above current priority is taken; lower or equal waits.
// - software levels come only from soft request or soft summary register writes.
// - taking a software level clears its pending bit.
// - levels 18-1F carry urgent conditions, serious errors and power failure.
// - priority lives in status bits 20:16 and rises to the taken level.
// - kernel software raises or lowers priority by a register write.
// - each instance holds its own priority, touching no other processor.
// - serious failures raise priority to 1F; other exceptions keep it.
// - traps save the address of the next instruction.
// - any mode may set and clear trap-enable bits by status instructions.
// - faults save the address of the faulting instruction.
// - aborts save the aborted opcode address; listed state may be unpredictable.
// - every event pushes status word and program counter.
// - interrupts always raise priority; exceptions normally leave it.
// - enabled exceptions start at once regardless of priority.
// - an exception while disabled is dropped, even if enabled later.
// - a held interrupt starts later if still asserted.
// - interrupts set previous mode to kernel; exceptions record the old mode.
// - interrupts use interrupt stack; return restores saved pc and status.
// - interrupts are taken only at instruction boundaries.
// - after initialization the priority is 31.
// - priority register uses bits 4:0; upper bits ignored and read zero.
// - soft request write marks level in bits 3:0 pending; zero does nothing.
`timescale 1ns/1ps
`default_nettype none
module piu_unit
    import piu_pkg::*;
#(
    parameter int TRAP_ENABLES = 3
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] hw_req,
    input wire logic at_boundary,
    input wire logic exc_req,
    input wire piu_exc_class_t exc_class,
    input wire logic exc_maskable,
    input wire logic [1:0] exc_enable_idx,
    input wire logic exc_severe,
    input wire logic [31:0] pc_current,
    input wire logic [31:0] pc_next,
    input wire logic status_bit_set_instr,
    input wire logic status_bit_clear_instr,
    input wire logic [2:0] status_bit_mask,
    input wire logic return_from_event,
    input wire logic [31:0] rfe_status,
    input wire logic [31:0] rfe_pc,
    output logic evt_valid,
    output logic evt_is_intr,
    output logic [4:0] evt_level,
    output logic evt_intr_stack,
    output logic [31:0] push_status,
    output logic [31:0] push_pc,
    output logic resume_valid,
    output logic [31:0] resume_pc,
    output logic [31:0] processor_status_word
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [31:0] psw_reg;
    logic [15:0] soft_pend_reg;
    logic [31:0] prdata_reg;
    logic evt_valid_reg;
    logic evt_is_intr_reg;
    logic [4:0] evt_level_reg;
    logic evt_intr_stack_reg;
    logic [31:0] push_status_reg;
    logic [31:0] push_pc_reg;
    logic resume_valid_reg;
    logic [31:0] resume_pc_reg;

    // highest set bit of a 16-bit request vector, and whether any is set
    function automatic logic [4:0] piu_top16(input logic [15:0] v);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < 16; i++)
        begin
            if (v[i])
            begin
                r = {1'b1, 4'(i)};
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // arbitration
    // ------------------------------------------------------------
    logic [4:0] processor_priority;
    logic [4:0] hw_top;
    logic [4:0] soft_top;
    logic [4:0] best_level;
    logic [1:0] cur_mode;
    logic [2:0] trap_en;
    logic exc_enabled;
    logic exc_take;
    logic int_take;
    logic soft_taken;

    assign processor_priority = psw_reg[PIU_SW_PRI_HI:PIU_SW_PRI_LO];
    assign cur_mode = psw_reg[PIU_SW_CMODE_HI:PIU_SW_CMODE_LO];
    assign trap_en = psw_reg[PIU_SW_TEN_HI:PIU_SW_TEN_LO];
    // hardware vector bit i is level 10h+i; bits 8-15 are urgent levels
    assign hw_top = piu_top16(hw_req);
    // soft levels keep bit 0 unused: level zero is no request
    assign soft_top = piu_top16(soft_pend_reg & 16'hFFFE);
    // any hardware level outranks every software level
    assign best_level = hw_top[4] ? (PIU_LVL_HW_BASE | {1'b0, hw_top[3:0]}) :
        (soft_top[4] ? {1'b0, soft_top[3:0]} :
        PIU_LVL_PROCESS);
    // a disabled trap source is dropped, not remembered
    assign exc_enabled = !exc_maskable || trap_en[exc_enable_idx];
    assign exc_take = exc_req && exc_enabled;
    // only above current priority, only between instructions
    assign int_take = !exc_req && at_boundary && (best_level > processor_priority);
    assign soft_taken = int_take && !best_level[4];

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic setup_ph;
    logic access_ph;
    logic wr_prio;
    logic wr_sreq;
    logic wr_ssum;
    logic kernel_ok;
    logic addr_ok;

    assign setup_ph = psel && !penable;
    assign access_ph = psel && penable;
    assign kernel_ok = (cur_mode == PIU_MODE_KERNEL);
    always_comb
    begin
        addr_ok = 1'b1;
        if (paddr == PIU_OFF_PRIORITY)
        begin
            addr_ok = 1'b1;
        end
        else if (paddr == PIU_OFF_SOFT_REQ)
        begin
            addr_ok = 1'b1;
        end
        else if (paddr == PIU_OFF_SOFT_SUM)
        begin
            addr_ok = 1'b1;
        end
        else if (paddr == PIU_OFF_STATUS)
        begin
            addr_ok = !pwrite; // status word is read-only here
        end
        else
        begin
            addr_ok = 1'b0;
        end
    end
    // privileged writes need kernel mode
    assign wr_prio = access_ph && pwrite && kernel_ok && (paddr == PIU_OFF_PRIORITY);
    assign wr_sreq = access_ph && pwrite && kernel_ok && (paddr == PIU_OFF_SOFT_REQ);
    assign wr_ssum = access_ph && pwrite && kernel_ok && (paddr == PIU_OFF_SOFT_SUM);
    assign pready = 1'b1;
    assign pslverr = access_ph && (!addr_ok || (pwrite && !kernel_ok));

    // read data captured in setup, shown in access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_reg <= 32'h0000_0000;
        end
        else if (setup_ph)
        begin
            if (pwrite)
            begin
                prdata_reg <= 32'h0000_0000;
            end
            else if (paddr == PIU_OFF_PRIORITY)
            begin
                prdata_reg <= {27'h0, processor_priority};
            end
            else if (paddr == PIU_OFF_SOFT_SUM)
            begin
                prdata_reg <= {16'h0000, soft_pend_reg & 16'hFFFE};
            end
            else if (paddr == PIU_OFF_STATUS)
            begin
                prdata_reg <= psw_reg;
            end
            else
            begin
                prdata_reg <= 32'h0000_0000; // request register reads zero
            end
        end
    end
    assign prdata = prdata_reg;

    // ------------------------------------------------------------
    // software pending summary
    // ------------------------------------------------------------
    logic [15:0] soft_set;
    logic [15:0] soft_clr;
    logic [15:0] soft_base;
    always_comb
    begin
        soft_set = 16'h0000;
        soft_clr = 16'h0000;
        soft_base = wr_ssum ? pwdata[15:0] : soft_pend_reg;
        if (wr_sreq && (pwdata[3:0] != 4'h0))
        begin
            soft_set[pwdata[3:0]] = 1'b1;
        end
        if (soft_taken)
        begin
            soft_clr[best_level[3:0]] = 1'b1;
        end
    end
    // a new request in the clearing cycle survives
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            soft_pend_reg <= PIU_SOFT_SUM_RESET[15:0];
        end
        else
        begin
            soft_pend_reg <= ((soft_base & ~soft_clr) | soft_set) & 16'hFFFE;
        end
    end

    // ------------------------------------------------------------
    // status word
    // ------------------------------------------------------------
    logic [31:0] psw_next;
    always_comb
    begin
        psw_next = psw_reg;
        if (exc_take)
        begin
            psw_next[PIU_SW_PMODE_HI:PIU_SW_PMODE_LO] = cur_mode;
            psw_next[PIU_SW_CMODE_HI:PIU_SW_CMODE_LO] = PIU_MODE_KERNEL;
            if (exc_severe)
            begin
                psw_next[PIU_SW_PRI_HI:PIU_SW_PRI_LO] = PIU_LVL_TOP;
            end
            // priority otherwise kept
        end
        else if (int_take)
        begin
            psw_next[PIU_SW_PRI_HI:PIU_SW_PRI_LO] = best_level;
            psw_next[PIU_SW_PMODE_HI:PIU_SW_PMODE_LO] = PIU_MODE_KERNEL;
            psw_next[PIU_SW_CMODE_HI:PIU_SW_CMODE_LO] = PIU_MODE_KERNEL;
            psw_next[PIU_SW_ISTACK] = 1'b1;
            psw_next[PIU_SW_FPD] = 1'b0;
        end
        else if (return_from_event)
        begin
            psw_next = rfe_status;
        end
        else if (status_bit_set_instr)
        begin
            psw_next[PIU_SW_TEN_HI:PIU_SW_TEN_LO] = trap_en | status_bit_mask;
        end
        else if (status_bit_clear_instr)
        begin
            psw_next[PIU_SW_TEN_HI:PIU_SW_TEN_LO] = trap_en & ~status_bit_mask;
        end
        else if (wr_prio)
        begin
            psw_next[PIU_SW_PRI_HI:PIU_SW_PRI_LO] = pwdata[4:0];
        end
    end
    // per-instance register, no shared priority state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            psw_reg <= PIU_SW_RESET;
        end
        else
        begin
            psw_reg <= psw_next;
        end
    end
    assign processor_status_word = psw_reg;

    // ------------------------------------------------------------
    // event push to the pipeline
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            evt_valid_reg <= 1'b0;
            evt_is_intr_reg <= 1'b0;
            evt_level_reg <= 5'h00;
            evt_intr_stack_reg <= 1'b0;
            push_status_reg <= 32'h0000_0000;
            push_pc_reg <= 32'h0000_0000;
        end
        else
        begin
            evt_valid_reg <= exc_take || int_take;
            if (exc_take || int_take)
            begin
                evt_is_intr_reg <= int_take;
                evt_level_reg <= psw_next[PIU_SW_PRI_HI:PIU_SW_PRI_LO];
                evt_intr_stack_reg <= psw_next[PIU_SW_ISTACK];
                push_status_reg <= psw_reg;
                // traps resume after, faults and aborts at the instruction
                if (int_take || (exc_class == PIU_EXC_TRAP))
                begin
                    push_pc_reg <= int_take ? pc_current : pc_next;
                end
                else
                begin
                    push_pc_reg <= pc_current;
                end
            end
        end
    end
    assign evt_valid = evt_valid_reg;
    assign evt_is_intr = evt_is_intr_reg;
    assign evt_level = evt_level_reg;
    assign evt_intr_stack = evt_intr_stack_reg;
    assign push_status = push_status_reg;
    assign push_pc = push_pc_reg;

    // return from event hands the saved pc back
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            resume_valid_reg <= 1'b0;
            resume_pc_reg <= 32'h0000_0000;
        end
        else
        begin
            resume_valid_reg <= return_from_event && !exc_take && !int_take;
            if (return_from_event && !exc_take && !int_take)
            begin
                resume_pc_reg <= rfe_pc;
            end
        end
    end
    assign resume_valid = resume_valid_reg;
    assign resume_pc = resume_pc_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_intr_raises_pri: assert property (@(posedge pclk) disable iff (!presetn)
        int_take |=> (processor_priority > $past(processor_priority)) && evt_valid)
        else $error("interrupt did not raise priority");
    a_no_low_take: assert property (@(posedge pclk) disable iff (!presetn)
        (at_boundary && !exc_req && best_level <= processor_priority) |=> !evt_is_intr || !evt_valid)
        else $error("interrupt taken at or below priority");
    a_soft_cleared: assert property (@(posedge pclk) disable iff (!presetn)
        (soft_taken && !(wr_sreq && pwdata[3:0] == best_level[3:0]) && !wr_ssum)
        |=> !soft_pend_reg[$past(best_level[3:0])])
        else $error("taken software level still pending");
    a_trap_pc_next: assert property (@(posedge pclk) disable iff (!presetn)
        (exc_take && exc_class == PIU_EXC_TRAP) |=> push_pc == $past(pc_next))
        else $error("trap saved wrong pc");
    a_fault_pc_cur: assert property (@(posedge pclk) disable iff (!presetn)
        (exc_take && exc_class != PIU_EXC_TRAP) |=> push_pc == $past(pc_current))
        else $error("fault or abort saved wrong pc");
    a_severe_top: assert property (@(posedge pclk) disable iff (!presetn)
        (exc_take && exc_severe) |=> processor_priority == PIU_LVL_TOP)
        else $error("severe failure did not reach top level");
    a_exc_keeps_pri: assert property (@(posedge pclk) disable iff (!presetn)
        (exc_take && !exc_severe) |=> $stable(processor_priority))
        else $error("exception changed priority");
    a_disabled_drop: assert property (@(posedge pclk) disable iff (!presetn)
        (exc_req && !exc_enabled) |=> !evt_valid)
        else $error("disabled exception initiated");
    a_prio_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_prio && !exc_take && !int_take && !return_from_event
        && !status_bit_set_instr && !status_bit_clear_instr)
        |=> processor_priority == $past(pwdata[4:0]))
        else $error("priority write lost");
    a_intr_kernel: assert property (@(posedge pclk) disable iff (!presetn)
        int_take |=> psw_reg[PIU_SW_PMODE_HI:PIU_SW_PMODE_LO] == PIU_MODE_KERNEL
        && psw_reg[PIU_SW_ISTACK])
        else $error("interrupt did not enter kernel on interrupt stack");
endmodule
`default_nettype wire

// ==== tb/piu_pipe_model.sv ====
// instruction pipeline stand-in that feeds boundary flags and program counters
`timescale 1ns/1ps
`default_nettype none
module piu_pipe_model
#(
    parameter logic [31:0] START_PC = 32'h0000_1000
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic boundary_en,
    input wire logic resume_valid,
    input wire logic [31:0] resume_pc,
    output logic at_boundary,
    output logic [31:0] pc_current,
    output logic [31:0] pc_next
);
    // ----
    // program counter
    // ----
    // runs ahead while executing, parks on a boundary, jumps on return
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pc_current <= START_PC;
        else if (resume_valid)
            pc_current <= resume_pc;
        else if (!boundary_en)
            pc_current <= pc_current + 32'h4;
    end
    // boundary flag and fall-through address
    assign at_boundary = boundary_en;
    assign pc_next = pc_current + 32'h4;
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench for the priority interrupt and exception unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import piu_pkg::*;
    // ----
    // signals
    // ----
    logic pclk, presetn, psel, penable, pwrite, exc_req, exc_maskable, exc_severe;
    logic status_bit_set_instr, status_bit_clear_instr, return_from_event, boundary_en;
    logic [7:0] paddr;
    logic [31:0] pwdata, rfe_status, rfe_pc, seed;
    logic [15:0] hw_req;
    logic [1:0] exc_enable_idx;
    logic [2:0] status_bit_mask;
    piu_exc_class_t exc_class;
    logic [31:0] prdata, push_status, push_pc, resume_pc, processor_status_word;
    logic [31:0] pc_current, pc_next, psw_prev;
    logic pready, pslverr, evt_valid, evt_is_intr, evt_intr_stack, resume_valid, at_boundary;
    logic [4:0] evt_level, p, lvl;
    logic [3:0] b;
    logic [32:0] apb_q[$];
    logic [32:0] ea;
    logic [38:0] ev_q[$];
    logic [38:0] ee;
    int error_cnt = 0;
    int checked = 0;

    piu_unit i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .hw_req, .at_boundary, .exc_req, .exc_class, .exc_maskable,
        .exc_enable_idx, .exc_severe, .pc_current, .pc_next, .status_bit_set_instr,
        .status_bit_clear_instr, .status_bit_mask, .return_from_event, .rfe_status, .rfe_pc,
        .evt_valid, .evt_is_intr, .evt_level, .evt_intr_stack, .push_status, .push_pc,
        .resume_valid, .resume_pc, .processor_status_word);
    piu_pipe_model i_pipe (.pclk, .presetn, .boundary_en, .resume_valid, .resume_pc,
        .at_boundary, .pc_current, .pc_next);

    // clock
    always #10 pclk = ~pclk;

    // ----
    // helpers
    // ----
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task check(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1)
        begin
            error_cnt++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    task finish_test;
        $display("mismatches %0d, checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task give_up(input string msg);
        check(1'b0, msg);
        finish_test;
    endtask
    // one bus transfer; the expected answer goes to the bus queue
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic er,
             input logic [31:0] ex);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        apb_q.push_back({er, ex});
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
            give_up("bus never answered");
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // expected event, noted once the parked pc has settled
    task note(input logic intr, input logic [4:0] l, input logic nxt);
        @(negedge pclk);
        ev_q.push_back({1'b0, intr, l, nxt ? pc_next : pc_current});
    endtask
    task drain;
        int n;
        n = 0;
        while (ev_q.size() != 0 && n < 100)
        begin
            @(posedge pclk);
            n++;
        end
        if (ev_q.size() != 0)
            give_up("event never came");
        @(posedge pclk);
    endtask
    task exc(input piu_exc_class_t c, input logic m, input logic s);
        @(posedge pclk);
        exc_req <= 1'b1;
        exc_class <= c;
        exc_maskable <= m;
        exc_severe <= s;
        @(posedge pclk);
        exc_req <= 1'b0;
        exc_severe <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
    task sbit(input logic set, input logic [2:0] m);
        @(posedge pclk);
        status_bit_set_instr <= set;
        status_bit_clear_instr <= !set;
        status_bit_mask <= m;
        @(posedge pclk);
        status_bit_set_instr <= 1'b0;
        status_bit_clear_instr <= 1'b0;
    endtask

    // ----
    // monitors
    // ----
    // bus answers against the bus queue
    always @(posedge pclk)
    begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && apb_q.size() != 0)
        begin
            ea = apb_q.pop_front();
            check(pslverr === ea[32], "bus error flag");
            if (!pwrite)
                check(prdata === ea[31:0], "read data");
        end
    end
    // initiated events and returns against the event queue
    always @(posedge pclk)
    begin
        if (evt_valid === 1'b1 || resume_valid === 1'b1)
        begin
            if (ev_q.size() == 0)
                check(1'b0, "event nobody asked for");
            else
            begin
                ee = ev_q.pop_front();
                if (ee[38])
                    check(resume_valid === 1'b1 && resume_pc === ee[31:0], "resume pc");
                else
                begin
                    check({evt_valid, evt_is_intr, evt_level, push_pc} === {1'b1, ee[37:0]},
                        "event fields");
                    check(push_status === psw_prev, "pushed status");
                    check(processor_status_word[20:16] === ee[36:32], "priority field");
                end
                if (ee[37])
                    check(evt_intr_stack === 1'b1, "stack choice");
            end
        end
        psw_prev = processor_status_word;
    end

    // ----
    // main sequence
    // ----
    initial
    begin
        {pclk, presetn, psel, penable, pwrite, exc_req, exc_maskable, exc_severe} = '0;
        {status_bit_set_instr, status_bit_clear_instr, return_from_event, boundary_en} = '0;
        {paddr, pwdata, rfe_status, rfe_pc, hw_req, exc_enable_idx, status_bit_mask} = '0;
        exc_class = PIU_EXC_TRAP;
        seed = 32'hB2A3;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, PIU_OFF_PRIORITY, 32'h0, 0, 32'h0000_001F);
        apb(0, PIU_OFF_STATUS, 32'h0, 0, 32'h001F_0000);
        apb(1, PIU_OFF_STATUS, 32'h0, 1, 32'h0);
        apb(0, 8'h10, 32'h0, 1, 32'h0);
        boundary_en <= 1'b1;
        apb(1, PIU_OFF_PRIORITY, 32'hFFFF_FFE8, 0, 32'h0);
        apb(0, PIU_OFF_PRIORITY, 32'h0, 0, 32'h0000_0008);
        apb(1, PIU_OFF_SOFT_REQ, 32'h3, 0, 32'h0);
        apb(1, PIU_OFF_SOFT_REQ, 32'h0, 0, 32'h0);
        apb(1, PIU_OFF_SOFT_REQ, 32'hFFFF_FFF7, 0, 32'h0);
        apb(0, PIU_OFF_SOFT_SUM, 32'h0, 0, 32'h0000_0088);
        note(1, 5'h09, 0);
        apb(1, PIU_OFF_SOFT_REQ, 32'h9, 0, 32'h0);
        drain;
        apb(0, PIU_OFF_SOFT_SUM, 32'h0, 0, 32'h0000_0088);
        hw_req <= 16'h0014;
        note(1, 5'h14, 0);
        drain;
        hw_req <= 16'h0004;
        note(1, 5'h12, 0);
        apb(1, PIU_OFF_PRIORITY, 32'h0, 0, 32'h0);
        drain;
        hw_req <= 16'h0000;
        note(1, 5'h07, 0);
        apb(1, PIU_OFF_PRIORITY, 32'h0, 0, 32'h0);
        drain;
        note(1, 5'h03, 0);
        apb(1, PIU_OFF_PRIORITY, 32'h0, 0, 32'h0);
        drain;
        apb(0, PIU_OFF_SOFT_SUM, 32'h0, 0, 32'h0);
        // random priority against one random hardware level
        for (int i = 0; i < 8; i++)
        begin
            seed = lfsr(seed);
            p = seed[4:0];
            b = seed[11:8];
            boundary_en <= 1'b0;
            apb(1, PIU_OFF_PRIORITY, {27'h0, p}, 0, 32'h0);
            @(posedge pclk);
            hw_req <= 16'h0001 << b;
            boundary_en <= 1'b1;
            lvl = 5'h10 + {1'b0, b};
            if (lvl <= p)
            begin
                repeat (4) @(posedge pclk);
                note(1, lvl, 0);
                apb(1, PIU_OFF_PRIORITY, 32'h0, 0, 32'h0);
            end
            else
                note(1, lvl, 0);
            drain;
            hw_req <= 16'h0000;
        end
        apb(1, PIU_OFF_PRIORITY, 32'h5, 0, 32'h0);
        note(0, 5'h05, 1);
        exc(PIU_EXC_TRAP, 0, 0);
        note(0, 5'h05, 0);
        exc(PIU_EXC_FAULT, 0, 0);
        note(0, 5'h05, 0);
        exc(PIU_EXC_ABORT, 0, 0);
        exc(PIU_EXC_TRAP, 1, 0);
        sbit(1, 3'b001);
        note(0, 5'h05, 1);
        exc(PIU_EXC_TRAP, 1, 0);
        sbit(0, 3'b001);
        exc(PIU_EXC_TRAP, 1, 0);
        note(0, 5'h1F, 0);
        exc(PIU_EXC_FAULT, 0, 1);
        drain;
        rfe_pc <= 32'h0000_4000;
        rfe_status <= 32'h0000_0000;
        return_from_event <= 1'b1;
        ev_q.push_back({1'b1, 6'h00, 32'h0000_4000});
        @(posedge pclk);
        return_from_event <= 1'b0;
        drain;
        apb(0, PIU_OFF_PRIORITY, 32'h0, 0, 32'h0);
        finish_test;
    end
endmodule
`default_nettype wire
